// ---- rtl/dovr_pkg.sv ----
`default_nettype none
package dovr_pkg;

    // Mode register addresses
    localparam logic [5:0] TERM_SEL_ADDR = 6'h0B;
    localparam logic [5:0] CA_REF_ADDR = 6'h0C;
    localparam logic [5:0] TRAIN_CTRL_ADDR = 6'h0D;

    // Termination field positions
    localparam int DQ_TERM_LSB = 0;
    localparam int CA_TERM_LSB = 4;
    localparam int NT_TERM_HI = 7;
    localparam int NT_TERM_LO = 3;

    // Reference register field positions
    localparam int REF_LEVEL_LSB = 0;
    localparam int REF_RANGE_BIT = 6;

    // Training control bit positions
    localparam int CBT_BIT = 0;
    localparam int RPT_BIT = 1;
    localparam int VRO_BIT = 2;
    localparam int FAST_REFERENCE_SETTLING_BIT = 3;
    localparam int RRO_BIT = 4;
    localparam int DMD_BIT = 5;
    localparam int FSPWR_BIT = 6;
    localparam int FSPOP_BIT = 7;

    // Reset values
    localparam logic [2:0] TERM_RESET = 3'h0;
    localparam logic [1:0] NT_TERM_RESET = 2'h0;
    localparam logic [5:0] REF_LEVEL_RESET = 6'h0D;
    localparam logic REF_RANGE_RESET = 1'b1;
    localparam logic [7:0] TRAIN_RESET = 8'h00;

    // Decode limits and codes
    localparam logic [2:0] TERM_RESERVED = 3'h7;
    localparam logic [5:0] REF_LEVEL_MAX = 6'h32;
    localparam logic [2:0] RATE_4X = 3'h1;
    localparam logic [2:0] RATE_2X = 3'h2;
    localparam logic [2:0] RATE_1X = 3'h3;

    // Per set point stored copy
    typedef struct packed {
        logic [2:0] dqTerm;
        logic [2:0] caTerm;
        logic [1:0] ntTerm;
        logic refRange;
        logic [5:0] refLevel;
    } dovr_fsp_t;

    // Mode register command
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [5:0] addr;
        logic [7:0] data;
    } dovr_cmd_t;

endpackage : dovr_pkg
`default_nettype wire

// ---- rtl/dovr_term_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
// Decodes a termination code into divider and enable
module dovr_term_decode (
    input wire logic [2:0] code,
    input wire logic nonTarget,
    output logic [2:0] divisor,
    output logic enable,
    output logic reserved
);

    // Code to divider map
    always_comb begin
        divisor = 3'h0;
        enable = 1'b0;
        reserved = 1'b0;
        if (nonTarget) begin
            case (code[1:0])
                2'h0: divisor = 3'h0;
                2'h1: divisor = 3'h3;
                2'h2: divisor = 3'h5;
                default: divisor = 3'h6;
            endcase
            enable = (code[1:0] != 2'h0);
        end else if (code == dovr_pkg::TERM_RESERVED) begin
            reserved = 1'b1;
        end else begin
            divisor = code;
            enable = (code != dovr_pkg::TERM_RESET);
        end
    end

endmodule : dovr_term_decode
`default_nettype wire

// ---- rtl/dovr_mode_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module dovr_mode_regs #(
    parameter bit RATE_OPTION_CAPABLE = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire dovr_pkg::dovr_cmd_t cmd,
    input wire logic cke,
    input wire logic [5:0] caIn,
    input wire logic calibPinGrounded,
    input wire logic calibCmd,
    input wire logic [2:0] sensorRate,
    input wire logic maskedWrite,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic [7:0] dqOut,
    output logic dqOe,
    output logic [2:0] dataBusTermDiv,
    output logic dataBusTermOn,
    output logic [2:0] cmdBusTermDiv,
    output logic cmdBusTermOn,
    output logic [2:0] nonTargetTermDiv,
    output logic nonTargetTermOn,
    output logic [5:0] cmdRefLevel,
    output logic cmdRefRange,
    output logic refCodeReserved,
    output logic fastSettling,
    output logic readPreambleTraining,
    output logic cmdBusTraining,
    output logic dataMaskEnabled,
    output logic maskedWriteIllegal,
    output logic calibRun,
    output logic useDefaultCalib,
    output logic [2:0] refreshRateReport
);

    // Two set point copies
    dovr_pkg::dovr_fsp_t fsp_r [2];
    // Training and set point control
    logic [7:0] trainCtrl_r;
    // Synchronised clock enable and inputs
    logic [1:0] ckeSync_r;
    logic [5:0] caMeta_r;
    logic [5:0] caSync_r;
    logic calibMeta_r;
    logic calibSync_r;

    // Write and operating set point selectors
    logic wrSel;
    logic opSel;
    dovr_pkg::dovr_fsp_t active;
    logic [2:0] unusedDiv;
    logic dqRes;
    logic caRes;
    logic ntRes;
    // Commands dropped while the bus trains with clock enable low
    logic cmdIgnored;

    assign wrSel = trainCtrl_r[dovr_pkg::FSPWR_BIT];
    // Only the synchronised clock enable is looked at
    assign cmdIgnored = trainCtrl_r[dovr_pkg::CBT_BIT] && !ckeSync_r[1];
    assign opSel = trainCtrl_r[dovr_pkg::FSPOP_BIT];
    assign active = fsp_r[opSel];

    // Returns one when a level code is legal
    function automatic logic level_ok(input logic [5:0] lvl);
        level_ok = (lvl <= dovr_pkg::REF_LEVEL_MAX);
    endfunction : level_ok

    // Pin synchronisers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ckeSync_r <= 2'h0;
            caMeta_r <= 6'h00;
            caSync_r <= 6'h00;
            calibMeta_r <= 1'b0;
            calibSync_r <= 1'b0;
        end else begin
            ckeSync_r <= {ckeSync_r[0], cke};
            caMeta_r <= caIn;
            caSync_r <= caMeta_r;
            calibMeta_r <= calibPinGrounded;
            calibSync_r <= calibMeta_r;
        end
    end

    // Set point copies, write reaches selected copy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 2; i++) begin
                fsp_r[i].dqTerm <= dovr_pkg::TERM_RESET;
                fsp_r[i].caTerm <= dovr_pkg::TERM_RESET;
                fsp_r[i].ntTerm <= dovr_pkg::NT_TERM_RESET;
                fsp_r[i].refRange <= dovr_pkg::REF_RANGE_RESET;
                fsp_r[i].refLevel <= dovr_pkg::REF_LEVEL_RESET;
            end
        end else if (cmd.wrEn && !cmdIgnored) begin
            case (cmd.addr)
                // Termination fields
                dovr_pkg::TERM_SEL_ADDR: begin
                    fsp_r[wrSel].dqTerm <= cmd.data[dovr_pkg::DQ_TERM_LSB +: 3];
                    fsp_r[wrSel].caTerm <= cmd.data[dovr_pkg::CA_TERM_LSB +: 3];
                    fsp_r[wrSel].ntTerm <= {cmd.data[dovr_pkg::NT_TERM_HI],
                                            cmd.data[dovr_pkg::NT_TERM_LO]};
                end
                // Reference level and range
                dovr_pkg::CA_REF_ADDR: begin
                    fsp_r[wrSel].refLevel <= cmd.data[dovr_pkg::REF_LEVEL_LSB +: 6];
                    fsp_r[wrSel].refRange <= cmd.data[dovr_pkg::REF_RANGE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Training control register, write-only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trainCtrl_r <= dovr_pkg::TRAIN_RESET;
        end else if (cmd.wrEn && !cmdIgnored && cmd.addr == dovr_pkg::TRAIN_CTRL_ADDR) begin
            trainCtrl_r <= cmd.data;
        end
    end

    // Read path: only the reference register is readable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= cmd.rdEn && !cmdIgnored;
            if (cmd.rdEn && !cmdIgnored && cmd.addr == dovr_pkg::CA_REF_ADDR) begin
                rdData <= {1'b0, fsp_r[wrSel].refRange, fsp_r[wrSel].refLevel};
            end else begin
                rdData <= 8'h00;
            end
        end
    end

    // Data pin driver: training mirror or reference output
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dqOut <= 8'h00;
            dqOe <= 1'b0;
        end else if (trainCtrl_r[dovr_pkg::CBT_BIT] && !ckeSync_r[1]) begin
            dqOut <= {2'h0, caSync_r};
            dqOe <= 1'b1;
        end else if (trainCtrl_r[dovr_pkg::VRO_BIT]) begin
            dqOut <= {1'b0, active.refRange, active.refLevel};
            dqOe <= 1'b1;
        end else begin
            dqOut <= 8'h00;
            dqOe <= 1'b0;
        end
    end

    // Refresh rate report with option folding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refreshRateReport <= dovr_pkg::RATE_1X;
        end else if (RATE_OPTION_CAPABLE && !trainCtrl_r[dovr_pkg::RRO_BIT] &&
                     (sensorRate == dovr_pkg::RATE_4X ||
                      sensorRate == dovr_pkg::RATE_2X)) begin
            refreshRateReport <= dovr_pkg::RATE_1X;
        end else begin
            refreshRateReport <= sensorRate;
        end
    end

    // Calibration gate from grounded resistor pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calibRun <= 1'b0;
        end else begin
            calibRun <= calibCmd && !calibSync_r;
        end
    end

    assign useDefaultCalib = calibSync_r;

    // Termination decoders on the operating copy
    dovr_term_decode uDq (
        .code(active.dqTerm),
        .nonTarget(1'b0),
        .divisor(dataBusTermDiv),
        .enable(dataBusTermOn),
        .reserved(dqRes)
    );
    dovr_term_decode uCa (
        .code(active.caTerm),
        .nonTarget(1'b0),
        .divisor(cmdBusTermDiv),
        .enable(cmdBusTermOn),
        .reserved(caRes)
    );
    dovr_term_decode uNt (
        .code({1'b0, active.ntTerm}),
        .nonTarget(1'b1),
        .divisor(nonTargetTermDiv),
        .enable(nonTargetTermOn),
        .reserved(ntRes)
    );
    assign unusedDiv = {dqRes, caRes, ntRes};

    // Operating outputs
    assign cmdRefLevel = active.refLevel;
    assign cmdRefRange = active.refRange;
    assign refCodeReserved = !level_ok(active.refLevel) || dqRes || caRes;
    assign fastSettling = trainCtrl_r[dovr_pkg::FAST_REFERENCE_SETTLING_BIT];
    assign readPreambleTraining = trainCtrl_r[dovr_pkg::RPT_BIT];
    assign cmdBusTraining = trainCtrl_r[dovr_pkg::CBT_BIT];
    assign dataMaskEnabled = !trainCtrl_r[dovr_pkg::DMD_BIT];
    assign maskedWriteIllegal = maskedWrite && trainCtrl_r[dovr_pkg::DMD_BIT];

    // Assertions: register writes and set point copies
    // Accepted reference write lands in the copy chosen at write time
    wr_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd.wrEn && !cmdIgnored && cmd.addr == dovr_pkg::CA_REF_ADDR |=>
        fsp_r[$past(wrSel)].refLevel == $past(cmd.data[5:0]))
        else $error("reference write missed selected copy");

    // Operating level follows the operating copy
    op_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmdRefLevel == fsp_r[opSel].refLevel)
        else $error("operation not on active copy");

    // Writing the inactive copy leaves operation alone
    wr_inactive_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd.wrEn && cmd.addr != dovr_pkg::TRAIN_CTRL_ADDR && wrSel != opSel |=>
        cmdRefLevel == $past(cmdRefLevel) && cmdRefRange == $past(cmdRefRange))
        else $error("inactive copy write changed operation");

    // Range of copy 0 kept until overwritten
    range_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(cmd.wrEn && cmd.addr == dovr_pkg::CA_REF_ADDR) |=>
        fsp_r[0].refRange == $past(fsp_r[0].refRange))
        else $error("range changed without write");

    // Training control takes the whole written byte
    train_wr_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd.wrEn && !cmdIgnored && cmd.addr == dovr_pkg::TRAIN_CTRL_ADDR |=>
        trainCtrl_r == $past(cmd.data))
        else $error("training write lost");

    // Assertions: read path
    // Unused top bit of a read is zero
    rd_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        rdValid |-> rdData[7] == 1'b0)
        else $error("reserved read bit not zero");

    // Reference read returns the write-selected copy
    rd_ref_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd.rdEn && !cmdIgnored && cmd.addr == dovr_pkg::CA_REF_ADDR && !cmd.wrEn |=>
        rdData[6:0] == {fsp_r[wrSel].refRange, fsp_r[wrSel].refLevel})
        else $error("reference read mismatch");

    // Write-only registers read back as zero
    rd_other_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmd.rdEn && cmd.addr != dovr_pkg::CA_REF_ADDR |=> rdData == 8'h00)
        else $error("unreadable register returned data");

    // Assertions: training and data pins
    // Dropped commands change no register and give no read
    cbt_ignore_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmdIgnored |=> !rdValid && trainCtrl_r == $past(trainCtrl_r) &&
        fsp_r[0] == $past(fsp_r[0]) && fsp_r[1] == $past(fsp_r[1]))
        else $error("command taken during bus training");

    // Synchronised address pins mirrored one cycle later
    cbt_mirror_a: assert property (@(posedge clk) disable iff (!rst_b)
        cmdBusTraining && !ckeSync_r[1] |=> dqOe && dqOut[5:0] == $past(caSync_r))
        else $error("training mirror missing");

    // Reference output shows the operating copy
    vro_out_a: assert property (@(posedge clk) disable iff (!rst_b)
        trainCtrl_r[dovr_pkg::VRO_BIT] && !cmdIgnored |=>
        dqOe && dqOut == {1'b0, $past(active.refRange), $past(active.refLevel)})
        else $error("reference output not from active copy");

    // Pins released outside training and reference output
    dq_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        !trainCtrl_r[dovr_pkg::VRO_BIT] && !cmdIgnored |=> !dqOe)
        else $error("data pins driven outside training");

    // Assertions: termination decode
    // Code zero and the reserved code leave termination off
    term_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        dataBusTermOn == (active.dqTerm != dovr_pkg::TERM_RESET &&
                          active.dqTerm != dovr_pkg::TERM_RESERVED) &&
        cmdBusTermOn == (active.caTerm != dovr_pkg::TERM_RESET &&
                         active.caTerm != dovr_pkg::TERM_RESERVED))
        else $error("termination enable disagrees with code");

    // Non-target termination on for every nonzero code
    nt_term_a: assert property (@(posedge clk) disable iff (!rst_b)
        nonTargetTermOn == (active.ntTerm != 2'h0))
        else $error("non-target enable disagrees with code");

    // Assertions: refresh report
    // Four-times rate folded to nominal
    rate_fold_a: assert property (@(posedge clk) disable iff (!rst_b)
        RATE_OPTION_CAPABLE && !trainCtrl_r[4] && sensorRate == 3'h1 |=>
        refreshRateReport == 3'h3)
        else $error("rate not folded to nominal");

    // Two-times rate folded to nominal
    half_rate_a: assert property (@(posedge clk) disable iff (!rst_b)
        RATE_OPTION_CAPABLE && !trainCtrl_r[dovr_pkg::RRO_BIT] &&
        sensorRate == dovr_pkg::RATE_2X |=> refreshRateReport == dovr_pkg::RATE_1X)
        else $error("half rate not folded to nominal");

    // Option set passes the sensor code through
    rate_raw_a: assert property (@(posedge clk) disable iff (!rst_b)
        trainCtrl_r[dovr_pkg::RRO_BIT] |=> refreshRateReport == $past(sensorRate))
        else $error("rate folded with option set");

    // Assertions: calibration and masking
    // Grounded resistor pin blocks calibration
    calib_ignore_a: assert property (@(posedge clk) disable iff (!rst_b)
        calibSync_r |=> !calibRun)
        else $error("calibration ran with grounded pin");

    // Connected resistor pin lets calibration run
    calib_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
        calibCmd && !calibSync_r |=> calibRun)
        else $error("calibration command lost");

    // Mask disable bit turns masking off
    mask_dis_a: assert property (@(posedge clk) disable iff (!rst_b)
        trainCtrl_r[5] |-> !dataMaskEnabled)
        else $error("mask not disabled");

    // Main scenarios
    cbt_c: cover property (@(posedge clk) disable iff (!rst_b) cmdBusTraining && dqOe);
    vro_c: cover property (@(posedge clk) disable iff (!rst_b) trainCtrl_r[2] && opSel);
    fsp1_wr_c: cover property (@(posedge clk) disable iff (!rst_b) cmd.wrEn && wrSel);
    rd_c: cover property (@(posedge clk) disable iff (!rst_b) rdValid && rdData != 8'h00);
    ignore_c: cover property (@(posedge clk) disable iff (!rst_b) cmdIgnored && cmd.wrEn);

endmodule : dovr_mode_regs
`default_nettype wire

// ---- dv/dovr_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Controller side: issues mode register commands and drives the pins
module dovr_ctrl_model (
    input wire logic clk,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    output var dovr_pkg::dovr_cmd_t cmd,
    output logic cke,
    output logic [5:0] caIn,
    output logic calibPinGrounded,
    output logic calibCmd,
    output logic [2:0] sensorRate,
    output logic maskedWrite
);
    // Idle levels from time zero
    initial begin
        cmd = '0;
        cke = 1'b1;
        caIn = 6'h00;
        calibPinGrounded = 1'b0;
        calibCmd = 1'b0;
        sensorRate = 3'h3;
        maskedWrite = 1'b0;
    end

    // One write command, held for a single cycle; callers never send reserved codes
    task automatic mr_write(input logic [5:0] addr, input logic [7:0] data);
        @(posedge clk);
        cmd <= '{1'b1, 1'b0, addr, data};
        @(posedge clk);
        cmd <= '0;
    endtask : mr_write

    // One read command; answer taken one cycle later
    task automatic mr_read(input logic [5:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clk);
        cmd <= '{1'b0, 1'b1, addr, 8'h00};
        @(posedge clk);
        cmd <= '0;
        #1;
        data = rdData;
        ok = rdValid;
    endtask : mr_read

    // Level pins; clock enable is raised before leaving training
    task automatic set_pins(input logic ck, input logic [5:0] ca, input logic gnd,
            input logic [2:0] rate);
        @(posedge clk);
        cke <= ck;
        caIn <= ca;
        calibPinGrounded <= gnd;
        sensorRate <= rate;
    endtask : set_pins

    // One-cycle pulse: calibration command or masked write
    task automatic pulse(input logic isMask);
        @(posedge clk);
        if (isMask) maskedWrite <= 1'b1;
        else calibCmd <= 1'b1;
        @(posedge clk);
        maskedWrite <= 1'b0;
        calibCmd <= 1'b0;
    endtask : pulse
endmodule : dovr_ctrl_model
`default_nettype wire

// ---- dv/dram_odt_vref_fsp_mode_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Register-level bench for the mode register block
module dram_odt_vref_fsp_mode_regs_tb_top;
    logic clk;
    logic rst_b;
    int errors;
    int numChecks;
    dovr_pkg::dovr_cmd_t cmd;
    logic cke, calibPinGrounded, calibCmd, maskedWrite, rdValid, dqOe, dataBusTermOn;
    logic cmdBusTermOn, nonTargetTermOn, cmdRefRange, refCodeReserved, fastSettling;
    logic readPreambleTraining, cmdBusTraining, dataMaskEnabled, maskedWriteIllegal;
    logic calibRun, useDefaultCalib, ok, seen;
    logic [5:0] caIn, cmdRefLevel;
    logic [2:0] sensorRate, dataBusTermDiv, cmdBusTermDiv, nonTargetTermDiv, refreshRateReport;
    logic [7:0] rdData, dqOut, rd;
    logic [2:0] ntDiv [4] = '{3'h0, 3'h3, 3'h5, 3'h6}; // Expected non-target divisors

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    dovr_ctrl_model ctrl (.clk(clk), .rdData(rdData), .rdValid(rdValid), .cmd(cmd), .cke(cke),
        .caIn(caIn), .calibPinGrounded(calibPinGrounded), .calibCmd(calibCmd),
        .sensorRate(sensorRate), .maskedWrite(maskedWrite));

    dovr_mode_regs dut (.clk(clk), .rst_b(rst_b), .cmd(cmd), .cke(cke), .caIn(caIn),
        .calibPinGrounded(calibPinGrounded), .calibCmd(calibCmd), .sensorRate(sensorRate),
        .maskedWrite(maskedWrite), .rdData(rdData), .rdValid(rdValid), .dqOut(dqOut),
        .dqOe(dqOe), .dataBusTermDiv(dataBusTermDiv), .dataBusTermOn(dataBusTermOn),
        .cmdBusTermDiv(cmdBusTermDiv), .cmdBusTermOn(cmdBusTermOn),
        .nonTargetTermDiv(nonTargetTermDiv), .nonTargetTermOn(nonTargetTermOn),
        .cmdRefLevel(cmdRefLevel), .cmdRefRange(cmdRefRange), .refCodeReserved(refCodeReserved),
        .fastSettling(fastSettling), .readPreambleTraining(readPreambleTraining),
        .cmdBusTraining(cmdBusTraining), .dataMaskEnabled(dataMaskEnabled),
        .maskedWriteIllegal(maskedWriteIllegal), .calibRun(calibRun),
        .useDefaultCalib(useDefaultCalib), .refreshRateReport(refreshRateReport));

    // Compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        numChecks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Wait n edges, then let updates land
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // Calibration pulse while watching for a run
    task automatic calib_try(output logic hit);
        hit = 1'b0;
        fork
            ctrl.pulse(1'b0);
            repeat (4) begin
                @(posedge clk);
                #1;
                if (calibRun === 1'b1) hit = 1'b1;
            end
        join
    endtask : calib_try

    // Masked write pulse, illegal flag seen while it is high
    task automatic mask_try(input logic exp);
        fork
            ctrl.pulse(1'b1);
            begin
                @(posedge clk);
                #1;
                chk("maskIllegal", {7'h0, exp}, {7'h0, maskedWriteIllegal});
            end
        join
    endtask : mask_try

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Hang guard
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        errors = 0;
        numChecks = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        settle(0);
        chk("refLevel", 8'h0D, {2'h0, cmdRefLevel});
        chk("dqTermOn", 8'h00, {7'h0, dataBusTermOn});
        chk("rateRpt", 8'h03, {5'h0, refreshRateReport});
        chk("maskEnRst", 8'h01, {7'h0, dataMaskEnabled});
        ctrl.mr_read(6'h0C, rd, ok);
        chk("refRead", 8'h4D, rd);
        chk("rdValid", 8'h01, {7'h0, ok});
        ctrl.mr_read(6'h0D, rd, ok);
        chk("ctlRead", 8'h00, rd);
        $display("test reset done");
        // Every non-target code, varied bus codes
        for (int i = 0; i < 4; i++) begin
            ctrl.mr_write(6'h0B, {i[1], 3'(6 - i), i[0], 3'(i + 1)});
            settle(0);
            chk("dqDiv", 8'(i + 1), {5'h0, dataBusTermDiv});
            chk("caDiv", 8'(6 - i), {5'h0, cmdBusTermDiv});
            chk("ntDiv", {5'h0, ntDiv[i]}, {5'h0, nonTargetTermDiv});
            chk("ntOn", {7'h0, i != 0}, {7'h0, nonTargetTermOn});
        end
        ctrl.mr_write(6'h0B, 8'h00);
        settle(0);
        chk("caOn", 8'h00, {7'h0, cmdBusTermOn});
        $display("test termination done");
        // Set point copies
        ctrl.mr_write(6'h0D, 8'h40);
        ctrl.mr_write(6'h0C, 8'h45);
        settle(0);
        chk("activeLvl", 8'h0D, {2'h0, cmdRefLevel});
        ctrl.mr_read(6'h0C, rd, ok);
        chk("copy1Read", 8'h45, rd);
        ctrl.mr_write(6'h0D, 8'hC0);
        settle(0);
        chk("activeLvl", 8'h05, {2'h0, cmdRefLevel});
        ctrl.mr_write(6'h0D, 8'h80);
        ctrl.mr_read(6'h0C, rd, ok);
        chk("copy0Read", 8'h4D, rd);
        ctrl.mr_write(6'h0C, 8'h32);
        settle(0);
        chk("activeRng", 8'h01, {7'h0, cmdRefRange});
        ctrl.mr_write(6'h0D, 8'h00);
        settle(2);
        chk("heldRng", 8'h00, {7'h0, cmdRefRange});
        chk("maxLvl", 8'h32, {2'h0, cmdRefLevel});
        chk("lvlRsvd", 8'h00, {7'h0, refCodeReserved});
        $display("test set point done");
        // Training control bits
        ctrl.mr_write(6'h0D, 8'h2A);
        settle(0);
        chk("preamble", 8'h01, {7'h0, readPreambleTraining});
        chk("fastSet", 8'h01, {7'h0, fastSettling});
        chk("maskEn", 8'h00, {7'h0, dataMaskEnabled});
        mask_try(1'b1);
        ctrl.mr_write(6'h0D, 8'h04);
        mask_try(1'b0);
        settle(3);
        chk("refOutOe", 8'h01, {7'h0, dqOe});
        chk("refOut", 8'h32, dqOut);
        ctrl.mr_write(6'h0D, 8'h01);
        settle(0);
        chk("cbt", 8'h01, {7'h0, cmdBusTraining});
        ctrl.set_pins(1'b0, 6'h2B, 1'b0, 3'h3);
        settle(2);
        ctrl.mr_write(6'h0B, 8'h11);
        ctrl.mr_read(6'h0C, rd, ok);
        chk("rdIgnored", 8'h00, {7'h0, ok});
        settle(4);
        chk("mirror", 8'h2B, dqOut);
        chk("mirrorOe", 8'h01, {7'h0, dqOe});
        chk("ignored", 8'h00, {7'h0, dataBusTermOn});
        ctrl.set_pins(1'b1, 6'h2B, 1'b0, 3'h1);
        settle(4);
        ctrl.mr_write(6'h0D, 8'h00);
        settle(3);
        chk("cbtOff", 8'h00, {7'h0, cmdBusTraining});
        chk("fold4x", 8'h03, {5'h0, refreshRateReport});
        $display("test training done");
        // Refresh report folding
        ctrl.set_pins(1'b1, 6'h00, 1'b0, 3'h2);
        settle(4);
        chk("fold2x", 8'h03, {5'h0, refreshRateReport});
        ctrl.mr_write(6'h0D, 8'h10);
        settle(4);
        chk("raw2x", 8'h02, {5'h0, refreshRateReport});
        $display("test refresh done");
        // Calibration with grounded and connected pin
        ctrl.set_pins(1'b1, 6'h00, 1'b1, 3'h2);
        settle(4);
        chk("dfltCal", 8'h01, {7'h0, useDefaultCalib});
        calib_try(seen);
        chk("calIgnored", 8'h00, {7'h0, seen});
        ctrl.set_pins(1'b1, 6'h00, 1'b0, 3'h2);
        settle(4);
        calib_try(seen);
        chk("calRun", 8'h01, {7'h0, seen});
        $display("test calibration done");
        // Reset in mid-run brings back the defaults
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        settle(1);
        chk("rstRng", 8'h01, {7'h0, cmdRefRange});
        chk("rstLvl", 8'h0D, {2'h0, cmdRefLevel});
        chk("rstRate", 8'h03, {5'h0, refreshRateReport});
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule : dram_odt_vref_fsp_mode_regs_tb_top
`default_nettype wire
